// file: shared/irq_pending_consts.svh
// constants for the interrupt pending-set, pending-clear and active-status registers
// Notes on behaviour
// - writing one to a pending-set bit makes that source pending; zeros do nothing
// - writing one to a pending-clear bit removes pending state; zeros do nothing
// - bits 16..0: debug, pins D..A, converter, MAC rx/tx/timer, security, serial, sleep timer, baseband, management, timers
// - read-only active-status register shows each active source on the same bit
// - pending-clear register decodes at its fixed address and resets to zero
// - active-status register decodes at its fixed address and reads zero after reset
`ifndef IRQ_PENDING_CONSTS_SVH
`define IRQ_PENDING_CONSTS_SVH

`define IRQ_PEND_SET_ADDR    32'hE000E200
`define IRQ_PEND_CLR_ADDR    32'hE000E280
`define IRQ_ACTIVE_ADDR      32'hE000E300
`define IRQ_SRC_COUNT        17
`define IRQ_PEND_RESET       17'h00000
`define IRQ_ACTIVE_RESET     17'h00000
`define IRQ_EXT_PIN_LSB      12
`define IRQ_EXT_PIN_COUNT    4
`define IRQ_EXT_PIN_RESET    4'h0
`define IRQ_UNUSED_LSB       17
`define IRQ_UNUSED_RESET     15'h0000

`endif

// file: shared/irq_pending_pkg.sv
// types for the interrupt pending and active register block
package irq_pending_pkg;

  // field order is the register bit order, bit 16 first
  typedef struct packed {
    logic debug_irq;
    logic ext_pin_d_irq;
    logic ext_pin_c_irq;
    logic ext_pin_b_irq;
    logic ext_pin_a_irq;
    logic converter_irq;
    logic mac_receive_irq;
    logic mac_transmit_irq;
    logic mac_timer_irq;
    logic security_irq;
    logic serial2_irq;
    logic serial1_irq;
    logic sleep_timer_irq;
    logic baseband_irq;
    logic management_irq;
    logic timer_two_irq;
    logic timer_one_irq;
  } irq_src_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    irq_src_type pend;
    irq_src_type act;
    logic [3:0]  pin_meta;
    logic [3:0]  pin_sync;
    irq_src_type src_prev;
  } state_type;

endpackage

// file: core/irq_pending_active_regs.sv
// interrupt pending-set, pending-clear and active-status registers on a wishbone slave
//
// The Wishbone interface to the registers was left to the implementer.
`include "irq_pending_consts.svh"

module irq_pending_active_regs
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire irq_pending_pkg::wb_req_type wb_req_i,
  output logic                             wb_ack_o,
  output logic [31:0]                      wb_dat_o,
  input  wire irq_pending_pkg::irq_src_type src_i,
  input  wire irq_pending_pkg::irq_src_type taken_i,
  input  wire irq_pending_pkg::irq_src_type active_i,
  output irq_pending_pkg::irq_src_type     pending_o,
  output irq_pending_pkg::irq_src_type     active_o
);

  irq_pending_pkg::state_type s_q;
  irq_pending_pkg::state_type s_d;

  localparam irq_pending_pkg::state_type STATE_RESET = '{
    ack:      1'b0,
    rdat:     32'h00000000,
    pend:     `IRQ_PEND_RESET,
    act:      `IRQ_ACTIVE_RESET,
    pin_meta: `IRQ_EXT_PIN_RESET,
    pin_sync: `IRQ_EXT_PIN_RESET,
    src_prev: `IRQ_PEND_RESET
  };

  // full-word match of a byte address against a register address
  function automatic logic reg_hit(input logic [31:0] adr, input logic [31:0] base);
    reg_hit = (adr[31:2] == base[31:2]);
  endfunction

  // expand byte selects into a mask over the implemented low bits
  function automatic logic [16:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    lane_mask = m[16:0];
  endfunction

  logic        req;
  logic        wr_now;
  logic [16:0] wmask;
  logic [16:0] set_bits;
  logic [16:0] clr_bits;
  logic [16:0] src_now;
  logic [16:0] src_rise;

  always_comb
  begin
    req = wb_req_i.cyc & wb_req_i.stb;
    // a write lands on the edge where the master sees ack
    wr_now = req & wb_req_i.we & s_q.ack;
    wmask = wb_req_i.dat[16:0] & lane_mask(wb_req_i.sel);

    set_bits = 17'h00000;
    clr_bits = 17'h00000;
    if (wr_now && reg_hit(wb_req_i.adr, `IRQ_PEND_SET_ADDR))
    begin
      set_bits = wmask;
    end
    if (wr_now && reg_hit(wb_req_i.adr, `IRQ_PEND_CLR_ADDR))
    begin
      clr_bits = wmask;
    end

    // external pins pass the synchroniser, all other sources are on this clock
    src_now = 17'(src_i);
    src_now[`IRQ_EXT_PIN_LSB +: `IRQ_EXT_PIN_COUNT] = s_q.pin_sync;
    src_rise = src_now & ~17'(s_q.src_prev);

    s_d = s_q;
    s_d.pin_meta = src_i[`IRQ_EXT_PIN_LSB +: `IRQ_EXT_PIN_COUNT];
    s_d.pin_sync = s_q.pin_meta;
    s_d.src_prev = irq_pending_pkg::irq_src_type'(src_now);
    s_d.act = active_i;

    // clear by software or by the core taking the interrupt; a new set wins
    s_d.pend = irq_pending_pkg::irq_src_type'(
      (17'(s_q.pend) & ~(clr_bits | 17'(taken_i))) | set_bits | src_rise);

    s_d.ack = req & ~s_q.ack;
    s_d.rdat = 32'h00000000;
    if (req && !s_q.ack && !wb_req_i.we)
    begin
      if (reg_hit(wb_req_i.adr, `IRQ_PEND_SET_ADDR) ||
          reg_hit(wb_req_i.adr, `IRQ_PEND_CLR_ADDR))
      begin
        s_d.rdat = {`IRQ_UNUSED_RESET, 17'(s_q.pend)};
      end
      else if (reg_hit(wb_req_i.adr, `IRQ_ACTIVE_ADDR))
      begin
        s_d.rdat = {`IRQ_UNUSED_RESET, 17'(s_q.act)};
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= STATE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o  = s_q.ack;
  assign wb_dat_o  = s_q.rdat;
  assign pending_o = s_q.pend;
  assign active_o  = s_q.act;

endmodule

// file: verif/irq_pending_monitor.sv
// assertion checker for the pending and active register block
`include "irq_pending_consts.svh"
module irq_pending_monitor
(
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire irq_pending_pkg::wb_req_type  wb_req_i,
  input wire logic                         wb_ack_o,
  input wire logic [31:0]                  wb_dat_o,
  input wire irq_pending_pkg::irq_src_type active_i,
  input wire irq_pending_pkg::irq_src_type pending_o,
  input wire irq_pending_pkg::irq_src_type active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [16:0] p = pending_o, v = active_o, w = wb_req_i.dat[16:0];
  wire logic go = wb_req_i.cyc & wb_req_i.stb & !wb_ack_o;
  wire logic rd = go & !wb_req_i.we;
  wire logic wr = wb_req_i.cyc & wb_req_i.stb & wb_ack_o & wb_req_i.we & (&wb_req_i.sel);
  wire logic hs = wb_req_i.adr == `IRQ_PEND_SET_ADDR;
  wire logic hc = wb_req_i.adr == `IRQ_PEND_CLR_ADDR;
  wire logic ht = wb_req_i.adr == `IRQ_ACTIVE_ADDR;
  sequence ack_pulse; ##1 wb_ack_o ##1 !wb_ack_o; endsequence
  ack_once_a: assert property (go |-> ack_pulse) else $error("ack width");
  set_pend_a: assert property (wr && hs |=> (p & $past(w)) == $past(w)) else $error("set");
  clr_pend_a: assert property (wr && hc |=> (p & $past(w)) == 0) else $error("clear");
  clr_read_a: assert property (rd && hc |=> wb_dat_o == {15'h0, $past(p)}) else $error("rd");
  act_read_a: assert property (rd && ht |=> wb_dat_o == {15'h0, $past(v)}) else $error("ra");
  act_flop_a: assert property (!$past(rst_i) |-> v == $past(active_i)) else $error("act");
  act_write_a: assert property (wr && ht |=> $stable(p)) else $error("act write");
endmodule
bind irq_pending_active_regs irq_pending_monitor u_irq_pending_monitor (.*);

// file: verif/irq_core_model.sv
// core model that takes every pending source and marks it active
module irq_core_model
(
  input  wire logic                         clk_i,
  input  wire logic                         take_i,
  input  wire irq_pending_pkg::irq_src_type pend_i,
  output irq_pending_pkg::irq_src_type      taken_o = '0,
  output irq_pending_pkg::irq_src_type      act_o = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk_i)
  begin
    taken_o <= take_i ? pend_i : '0;
    act_o <= take_i ? act_o | pend_i : '0;
  end
endmodule

// file: verif/irq_pending_active_regs_tb_top.sv
// self-checking testbench for the pending and active register block
`include "irq_pending_consts.svh"
module irq_pending_active_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                         clk_i, rst_i, take, ack;
  logic [31:0]                  r, d, seed, dat;
  logic [16:0]                  ep;
  int                           errors, check_count, i;
  logic [3:0]                   bsel;
  irq_pending_pkg::wb_req_type  req;
  irq_pending_pkg::irq_src_type src, tk, act, pend, act_out;
  irq_pending_active_regs u_irq_pending_active_regs (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(dat), .src_i(src), .taken_i(tk),
    .active_i(act), .pending_o(pend), .active_o(act_out));
  irq_core_model u_irq_core_model (.clk_i(clk_i), .take_i(take), .pend_i(pend),
    .taken_o(tk), .act_o(act));
  task automatic wb(input logic w, input logic [31:0] a, v, output logic [31:0] q);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, w, bsel, a, v};
    // hold the request until ack is seen high at a rising edge
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, ack, 1'b1);
    end
    q = dat;
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #4 clk_i = ~clk_i;
  initial
  begin
    #20000;
    errors++;
    final_report;
  end
  initial
  begin
    {clk_i, take, req, src, ep, errors, check_count} = 0;
    rst_i = 1'b1;
    seed = 32'hC8B2;
    bsel = 4'hF;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, `IRQ_PEND_CLR_ADDR, 0, r);
    chk(r, 0);
    wb(0, `IRQ_ACTIVE_ADDR, 0, r);
    chk(r, 0);
    $display("reset test done");
    for (i = 0; i < 8; i++)
    begin
      d = $random(seed);
      wb(1, i[0] ? `IRQ_PEND_SET_ADDR : `IRQ_PEND_CLR_ADDR, d, r);
      ep = i[0] ? ep | d[16:0] : ep & ~d[16:0];
      wb(1, i[1] ? `IRQ_ACTIVE_ADDR : 32'hE000E404, ~d, r);
      wb(0, i[1] ? `IRQ_PEND_CLR_ADDR : 32'hE000E404, 0, r);
      chk(r, i[1] ? {15'h0, ep} : 0);
      chk({pend.debug_irq, pend.timer_one_irq}, {ep[16], ep[0]});
    end
    // only the low byte lane is selected, so bits 16..8 must stay
    bsel = 4'h1;
    wb(1, `IRQ_PEND_SET_ADDR, 32'h0001FFFF, r);
    ep = ep | 17'h000FF;
    bsel = 4'hF;
    wb(0, `IRQ_PEND_SET_ADDR, 0, r);
    chk(r, {15'h0, ep});
    $display("register test done");
    // baseband is on this clock, pin A passes the synchroniser first
    src <= 17'h01008;
    repeat (4) @(posedge clk_i);
    chk(pend, ep | 17'h1008);
    take <= 1'b1;
    repeat (3) @(posedge clk_i);
    wb(0, `IRQ_ACTIVE_ADDR, 0, r);
    chk(r, ep | 17'h1008);
    chk(pend, 0);
    $display("source test done");
    final_report;
  end
endmodule
